// ===== hdl/toc_channel.sv
// timer output channel: counter, period and duty compare, pwm/one-shot/shift
// Notes on behaviour
// - mode 11, one-shot 0, routing 0 gives continuous serial shift
// - shift mode, update off: period match does a shift, not a reload
// - period compare counts shifted bits of duty register, at most 23
// - external trigger plus reset-on-match: capture event resets counter
// - capture event is held and synchronised before it acts
// - capture reset lands on the selected clock enable, fixed or configurable
// - clock source select chooses fixed 0/1 or configurable 0..7 enable
// - fixed enable 0 divides by 1, fixed enable 1 by 16
// - one-shot: period compare sets the initial inactive phase length
// - counter width bounds the longest period
// - one-shot: active edge at period-1 then reset, inactive at duty-1
// - compares run in initial phase; enabled triggers raise interrupts
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module toc_channel
  import toc_pkg::*;
(
  input  wire logic             ref_clk,     // 100 MHz cluster clock
  input  wire logic             rst,         // async, active high
  input  wire logic [7:0]       addr,        // register byte address
  input  wire logic [31:0]      wdata,       // write data
  input  wire logic             wr,          // write strobe
  input  wire logic             rd,          // read strobe
  output logic      [31:0]      rdata,       // read data, cycle after rd
  input  wire logic [N_CFG-1:0] cfg_clk_en,  // configurable clock enables
  input  wire logic             capture_unit_event, // capture pulse
  output logic                  chan_out,    // channel output
  output logic                  first_compare_trigger,  // period match
  output logic                  second_compare_trigger, // duty match
  output logic                  irq          // level interrupt
);

  typedef struct packed {
    logic [13:0]      ctrl;
    logic [CNT_W-1:0] channel_counter;
    logic [CNT_W-1:0] period_compare;
    logic [CNT_W-1:0] duty_compare;
    logic [CNT_W-1:0] shift_reg;
    logic [CNT_W-1:0] shift_cnt;
    logic [3:0]       prescale;
    logic             cap_pend;
    logic             cap_sync;
    logic             oneshot_live;
    logic             out;
    logic             trig0;
    logic             trig1;
    logic [1:0]       irq_stat;
    logic [1:0]       irq_en;
    logic [31:0]      rdata;
  } toc_state_s;

  toc_state_s st_reg;
  toc_state_s st_next;

  function automatic logic [31:0] toc_pad(input logic [CNT_W-1:0] v);
    toc_pad = {8'h00, v};
  endfunction

  logic       tick;
  logic [2:0] src;
  logic       fixed_sel;
  logic       shift_mode;
  logic       one_shot;
  logic       cap_rst_en;
  logic       per_hit;
  logic       duty_hit;
  logic [CNT_W-1:0] shift_len;

  always_comb
  begin
    src        = st_reg.ctrl[F_SRC_LO +: 3];
    fixed_sel  = st_reg.ctrl[F_FIX];
    // fixed 0 undivided, fixed 1 every 16th clock
    if (fixed_sel)
      tick = (src[0]) ? (st_reg.prescale == FIX1_MASK) : 1'b1;
    else
      tick = cfg_clk_en[src];
    shift_mode = st_reg.ctrl[F_MODE_LO +: 2] == MODE_SHIFT &&
                 !st_reg.ctrl[F_OSM] && !st_reg.ctrl[F_ROUTE];
    one_shot   = st_reg.ctrl[F_OSM] &&
                 st_reg.ctrl[F_MODE_LO +: 2] == MODE_PWM;
    cap_rst_en = st_reg.ctrl[F_EXTERNAL_TRIGGER_SELECT] && st_reg.ctrl[F_RST_PM];
    // shift length clamps at the widest legal count
    shift_len  = (st_reg.period_compare > SHIFT_MAX) ?
                 SHIFT_MAX : st_reg.period_compare;
    // compare at value-1 so 0 and 1 both behave after a capture reset
    per_hit    = st_reg.channel_counter ==
                 st_reg.period_compare - 24'h000001;
    duty_hit   = st_reg.channel_counter ==
                 st_reg.duty_compare - 24'h000001;
  end

  always_comb
  begin
    st_next       = st_reg;
    st_next.trig0 = 1'b0;
    st_next.trig1 = 1'b0;
    st_next.rdata = 32'h00000000;
    st_next.prescale = st_reg.prescale + 4'h1;

    // capture is only latched here; it never acts before the tick
    if (capture_unit_event && cap_rst_en)
      st_next.cap_pend = 1'b1;
    st_next.cap_sync = st_reg.cap_pend;

    if (st_reg.ctrl[F_EN] && tick)
    begin
      if (st_reg.cap_sync && cap_rst_en)
      begin
        // counter restart aligned to the selected enable
        st_next.channel_counter = {CNT_W{1'b0}};
        st_next.cap_pend        = capture_unit_event;
        st_next.cap_sync        = 1'b0;
        st_next.out             = st_reg.duty_compare != 24'h0;
      end
      else if (shift_mode)
      begin
        st_next.out       = st_reg.shift_reg[0];
        st_next.shift_reg = {st_reg.shift_reg[0],
                             st_reg.shift_reg[CNT_W-1:1]};
        if (st_reg.shift_cnt + 24'h000001 >= shift_len)
        begin
          st_next.shift_cnt = {CNT_W{1'b0}};
          st_next.trig0     = 1'b1;
          // update off: keep shifting instead of a reload cycle
          if (st_reg.ctrl[F_UPDATE_ENABLE_FIELD_LO +: 2] != UPDATE_ENABLE_FIELD_OFF)
            st_next.shift_reg = st_reg.duty_compare;
        end
        else
          st_next.shift_cnt = st_reg.shift_cnt + 24'h000001;
        st_next.channel_counter = st_next.shift_cnt;
      end
      else
      begin
        // counter wraps at its width, bounding the period
        st_next.channel_counter = st_reg.channel_counter + 24'h000001;
        if (duty_hit)
        begin
          st_next.trig1 = 1'b1;
          st_next.out   = 1'b0;
          if (one_shot && !st_reg.oneshot_live)
            st_next.out = 1'b0;
        end
        if (per_hit)
        begin
          st_next.trig0           = 1'b1;
          st_next.channel_counter = {CNT_W{1'b0}};
          if (one_shot)
          begin
            // initial phase ends; pulse runs one period then stops
            st_next.out          = !st_reg.oneshot_live &&
                                   st_reg.duty_compare != 24'h0;
            st_next.oneshot_live = !st_reg.oneshot_live;
            if (st_reg.oneshot_live)
              st_next.ctrl[F_EN] = 1'b0;
          end
          else
            st_next.out = st_reg.duty_compare != 24'h0;
        end
      end
    end

    // sticky status, set wins over clear
    if (wr && addr == ADDR_IRQ_CLR)
      st_next.irq_stat = st_reg.irq_stat & ~wdata[1:0];
    st_next.irq_stat = st_next.irq_stat |
                       {st_next.trig1, st_next.trig0};

    if (wr)
    begin
      case (addr)
        ADDR_CTRL:
        begin
          st_next.ctrl         = wdata[13:0];
          st_next.oneshot_live = 1'b0;
        end
        ADDR_CNT:
        begin
          st_next.channel_counter = wdata[CNT_W-1:0];
          st_next.oneshot_live    = 1'b0;
          st_next.out             = 1'b0;
        end
        ADDR_PERIOD: st_next.period_compare = wdata[CNT_W-1:0];
        ADDR_DUTY:
        begin
          st_next.duty_compare = wdata[CNT_W-1:0];
          st_next.shift_reg    = wdata[CNT_W-1:0];
        end
        ADDR_IRQ_EN: st_next.irq_en = wdata[1:0];
        default: ;
      endcase
    end

    if (rd)
    begin
      case (addr)
        ADDR_CTRL:     st_next.rdata = {18'h0, st_reg.ctrl};
        ADDR_CNT:      st_next.rdata = toc_pad(st_reg.channel_counter);
        ADDR_PERIOD:   st_next.rdata = toc_pad(st_reg.period_compare);
        ADDR_DUTY:     st_next.rdata = toc_pad(st_reg.duty_compare);
        ADDR_IRQ_STAT: st_next.rdata = {30'h0, st_reg.irq_stat};
        ADDR_IRQ_EN:   st_next.rdata = {30'h0, st_reg.irq_en};
        ADDR_STATUS:   st_next.rdata = {29'h0, st_reg.oneshot_live,
                                        st_reg.cap_pend, st_reg.out};
        default:       st_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg      <= '0;
      st_reg.ctrl <= CTRL_RST;
    end
    else
      st_reg <= st_next;
  end

  assign rdata                  = st_reg.rdata;
  assign chan_out               = st_reg.out ^ st_reg.ctrl[F_POL];
  assign first_compare_trigger  = st_reg.trig0;
  assign second_compare_trigger = st_reg.trig1;
  assign irq                    = |(st_reg.irq_stat & st_reg.irq_en);

  // assertions
  sequence s_cap_taken;
    capture_unit_event && cap_rst_en && st_reg.ctrl[F_EN];
  endsequence

  a_cap_not_at_once: assert property (@(posedge ref_clk) disable iff (rst)
    s_cap_taken and (st_reg.channel_counter > 24'h1 && !st_reg.cap_sync
      && !wr && !shift_mode)
    |=> st_reg.channel_counter != 24'h0 || $past(per_hit))
    else $error("capture reset acted at once");

  a_cap_on_tick: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.ctrl[F_EN] && st_reg.cap_sync && cap_rst_en && tick && !wr
    |=> st_reg.channel_counter == 24'h0)
    else $error("capture reset missed the tick");

  a_no_tick_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !tick && !wr |=> $stable(st_reg.channel_counter))
    else $error("counter moved without enable");

  a_fix1_div: assert property (@(posedge ref_clk) disable iff (rst)
    fixed_sel && src[0] && tick |=> !tick [*8])
    else $error("fixed enable 1 not divided");

  a_per_reset: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.ctrl[F_EN] && tick && per_hit && !shift_mode && !wr
      && !(st_reg.cap_sync && cap_rst_en)
    |=> first_compare_trigger && st_reg.channel_counter == 24'h0)
    else $error("period match did not reset counter");

  a_duty_edge: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.ctrl[F_EN] && tick && duty_hit && !per_hit && !shift_mode
      && !wr && !(st_reg.cap_sync && cap_rst_en)
    |=> !st_reg.out && second_compare_trigger)
    else $error("duty match did not end pulse");

  a_irq_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    first_compare_trigger |-> st_reg.irq_stat[0])
    else $error("trigger not recorded");

  a_shift_len: assert property (@(posedge ref_clk) disable iff (rst)
    shift_mode |-> st_reg.shift_cnt <= SHIFT_MAX)
    else $error("shift count beyond limit");

  a_shift_cont: assert property (@(posedge ref_clk) disable iff (rst)
    shift_mode && st_reg.ctrl[F_EN] && tick && !wr
      && !(st_reg.cap_sync && cap_rst_en)
      && st_reg.ctrl[F_UPDATE_ENABLE_FIELD_LO +: 2] == UPDATE_ENABLE_FIELD_OFF
    |=> st_reg.shift_reg == {$past(st_reg.shift_reg[0]),
                             $past(st_reg.shift_reg[CNT_W-1:1])})
    else $error("shift stalled at period match");

  // raw field decode, so a broken shift_mode term is caught too
  a_shift_out: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.ctrl[F_MODE_LO +: 2] == MODE_SHIFT && !st_reg.ctrl[F_OSM]
      && !st_reg.ctrl[F_ROUTE] && st_reg.ctrl[F_EN] && tick && !wr
      && !(st_reg.cap_sync && cap_rst_en)
    |=> st_reg.out == $past(st_reg.shift_reg[0]))
    else $error("shift mode did not shift out");

  sequence s_shift_last;
    shift_mode && st_reg.ctrl[F_EN] && tick && !wr
      && !(st_reg.cap_sync && cap_rst_en)
      && st_reg.shift_cnt + 24'h000001 >= shift_len;
  endsequence

  // last bit of a frame: count restarts and the period trigger fires
  a_shift_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    s_shift_last |=> first_compare_trigger && st_reg.shift_cnt == 24'h0)
    else $error("shift count did not wrap");

  // a pending capture waits in the second stage until the tick
  a_cap_sync: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.cap_pend && !tick |=> st_reg.cap_sync)
    else $error("pending capture lost before tick");

  a_cap_out: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.ctrl[F_EN] && tick && st_reg.cap_sync && cap_rst_en && !wr
    |=> st_reg.out == (st_reg.duty_compare != 24'h0))
    else $error("output wrong after capture reset");

  sequence s_os_period;
    one_shot && st_reg.ctrl[F_EN] && tick && per_hit && !wr
      && !(st_reg.cap_sync && cap_rst_en);
  endsequence

  // first period match ends the inactive phase and starts the pulse
  a_os_arm: assert property (@(posedge ref_clk) disable iff (rst)
    s_os_period and !st_reg.oneshot_live
    |=> st_reg.oneshot_live && st_reg.channel_counter == 24'h0
      && st_reg.out == (st_reg.duty_compare != 24'h0))
    else $error("one-shot pulse did not start");

  // second match closes the pulse; channel disables itself
  a_os_stop: assert property (@(posedge ref_clk) disable iff (rst)
    s_os_period and st_reg.oneshot_live
    |=> !st_reg.ctrl[F_EN] && !st_reg.out && !st_reg.oneshot_live)
    else $error("one-shot did not stop after pulse");

  // free-running pwm: every period match with nonzero duty raises the active edge again
  a_pwm_rise: assert property (@(posedge ref_clk) disable iff (rst)
    !one_shot && !shift_mode && st_reg.ctrl[F_EN] && tick
      && per_hit && !wr
      && !(st_reg.cap_sync && cap_rst_en)
    |=> st_reg.out == (st_reg.duty_compare != 24'h0))
    else $error("period match did not start pulse");

  // duty trigger must leave its sticky bit behind, set beats clear
  a_duty_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    second_compare_trigger |-> st_reg.irq_stat[1])
    else $error("duty trigger not recorded");

endmodule
`default_nettype wire

// ===== hdl/toc_pkg.sv
// package for the timer output channel: register map, fields, constants
package toc_pkg;
  localparam int          CNT_W          = 24;
  // register word offsets (byte addresses)
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_CNT       = 8'h04;
  localparam logic [7:0]  ADDR_PERIOD    = 8'h08;
  localparam logic [7:0]  ADDR_DUTY      = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h18;
  localparam logic [7:0]  ADDR_STATUS    = 8'h1c;
  // control field positions
  localparam int          F_EN           = 0;
  localparam int          F_MODE_LO      = 1;
  localparam int          F_OSM          = 3;
  localparam int          F_ROUTE        = 4;
  localparam int          F_EXTERNAL_TRIGGER_SELECT     = 5;
  localparam int          F_RST_PM       = 6;
  localparam int          F_UPDATE_ENABLE_FIELD_LO      = 7;
  localparam int          F_SRC_LO       = 9;
  localparam int          F_FIX          = 12;
  localparam int          F_POL          = 13;
  localparam logic [13:0] CTRL_RST       = 14'h0000;
  localparam logic [1:0]  MODE_PWM       = 2'h2;
  localparam logic [1:0]  MODE_SHIFT     = 2'h3;
  localparam logic [1:0]  UPDATE_ENABLE_FIELD_OFF       = 2'h0;
  localparam logic [CNT_W-1:0] SHIFT_MAX = 24'h000017;
  localparam int          FIX1_SHIFT     = 4;
  localparam logic [3:0]  FIX1_MASK      = 4'hf;
  localparam int          N_CFG          = 8;
endpackage

// ===== testbench/tb.sv
// self-checking testbench for the timer output channel
`timescale 1ns/1ps
`default_nettype none
module tb;
  import toc_pkg::*;
  logic             ref_clk, rst, wr, rd, fire, cue;
  logic             chan_out, t0, t1, irq;
  logic [7:0]       addr;
  logic [31:0]      wdata, rdata, d, c;
  logic [N_CFG-1:0] cfg_clk_en;
  int               errors, n_tests, cyc, g, h, k;
  toc_channel i_toc_channel (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cfg_clk_en(cfg_clk_en), .capture_unit_event(cue), .chan_out(chan_out),
    .first_compare_trigger(t0), .second_compare_trigger(t1), .irq(irq));
  toc_partner i_toc_partner (.ref_clk(ref_clk), .rst(rst), .fire(fire),
    .cfg_clk_en(cfg_clk_en), .capture_unit_event(cue));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic o,
      input logic x, input logic [2:0] s, input logic f);
    ctl = 32'h1 | 32'(m) << F_MODE_LO | 32'(o) << F_OSM
      | 32'(x) << F_EXTERNAL_TRIGGER_SELECT | 32'(x) << F_RST_PM | 32'(s) << F_SRC_LO
      | 32'(f) << F_FIX;
  endfunction
  // cycles until the watched output is next seen high
  task automatic gap(input int w, output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while ((w == 0 ? t0 : w == 1 ? t1 : chan_out) !== 1'b1 && n < 3000);
  endtask
  task automatic tick4;
    do
    begin
      @(posedge ref_clk);
      #1;
    end
    while (cfg_clk_en[4] !== 1'b1);
  endtask
  task automatic t_pwm;
    rd_reg(8'h20);
    check(d, 32'h0);
    wr_reg(ADDR_PERIOD, 32'h5);
    wr_reg(ADDR_DUTY, 32'h2);
    wr_reg(ADDR_CTRL, ctl(MODE_PWM, 1'b0, 1'b0, 3'h0, 1'b1));
    gap(0, g);
    gap(0, g);
    check(32'(g), 32'd5);
    gap(1, g);
    gap(1, g);
    check(32'(g), 32'd5);
    wr_reg(ADDR_CTRL, ctl(MODE_PWM, 1'b0, 1'b0, 3'h1, 1'b1));
    gap(0, g);
    gap(0, g);
    check(32'(g), 32'd80);
    wr_reg(ADDR_CTRL, ctl(MODE_PWM, 1'b0, 1'b0, 3'h2, 1'b0));
    gap(0, g);
    gap(0, g);
    check(32'(g), 32'd20);
  endtask
  task automatic t_irq;
    check(32'(irq), 32'h0);
    wr_reg(ADDR_IRQ_EN, 32'h1);
    gap(0, g);
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'(irq), 32'h1);
    rd_reg(ADDR_IRQ_STAT);
    check(d & 32'h1, 32'h1);
    wr_reg(ADDR_IRQ_EN, 32'h0);
    wr_reg(ADDR_IRQ_CLR, 32'h3);
    @(posedge ref_clk);
    #1;
    check(32'(irq), 32'h0);
  endtask
  // start 3 shortens the inactive phase by exactly 3 ticks
  task automatic t_oneshot;
    wr_reg(ADDR_PERIOD, 32'h6);
    wr_reg(ADDR_DUTY, 32'h2);
    for (int s = 0; s < 4; s += 3)
    begin
      wr_reg(ADDR_CTRL, ctl(MODE_PWM, 1'b1, 1'b0, 3'h0, 1'b1));
      wr_reg(ADDR_CNT, 32'(s));
      gap(2, h);
      k = 0;
      while (chan_out === 1'b1 && k < 100)
      begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      check(32'(k), 32'd2);
      if (s == 0)
        g = h;
    end
    check(32'(g - h), 32'd3);
    repeat (10) @(posedge ref_clk);
    rd_reg(ADDR_CTRL);
    check(d & 32'h1, 32'h0);
  endtask
  task automatic t_shift;
    wr_reg(ADDR_PERIOD, 32'(SHIFT_MAX));
    wr_reg(ADDR_DUTY, 32'h1);
    wr_reg(ADDR_CTRL, ctl(MODE_SHIFT, 1'b0, 1'b0, 3'h0, 1'b1));
    gap(2, g);
    gap(2, g);
    check(32'(g), 32'd24);
    gap(2, g);
    check(32'(g), 32'd24);
    gap(0, g);
    gap(0, g);
    check(32'(g), 32'd23);
  endtask
  // capture lands mid-interval; counter must hold until the next tick
  task automatic t_capture;
    wr_reg(ADDR_PERIOD, 32'd100);
    wr_reg(ADDR_DUTY, 32'h1);
    wr_reg(ADDR_CTRL, ctl(MODE_PWM, 1'b0, 1'b1, 3'h4, 1'b0));
    repeat (50) @(posedge ref_clk);
    tick4();
    rd_reg(ADDR_CNT);
    c = d;
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    rd_reg(ADDR_CNT);
    check(d, c);
    tick4();
    rd_reg(ADDR_CNT);
    check(d, 32'h0);
    check(32'(chan_out), 32'h1);
    rd_reg(ADDR_STATUS);
    check(d, 32'h1);
  endtask
  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    fire = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_pwm();
    t_irq();
    t_oneshot();
    t_shift();
    t_capture();
    finish_test();
  end
endmodule
`default_nettype wire

// ===== testbench/toc_partner.sv
// far-side model: divided clock enables and capture events
`timescale 1ns/1ps
`default_nettype none
module toc_partner
  import toc_pkg::*;
(
  input  wire logic             ref_clk,           // cluster clock
  input  wire logic             rst,               // async, active high
  input  wire logic             fire,              // bench asks for capture
  output logic      [N_CFG-1:0] cfg_clk_en,        // enable i every 2**i
  output logic                  capture_unit_event // one-cycle capture
);
  logic [7:0] div_reg;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg <= 8'h00;
      capture_unit_event <= 1'b0;
    end
    else
    begin
      div_reg <= div_reg + 8'h01;
      capture_unit_event <= fire;
    end
  end
  // enable 0 stays high: undivided cluster clock
  always_comb
  begin
    for (int i = 0; i < N_CFG; i++)
      cfg_clk_en[i] = (div_reg & ((8'h01 << i) - 8'h01)) == 8'h00;
  end
endmodule
`default_nettype wire
